// ===== msci_pkg.sv
// constants and types for the modem status / control / interrupt block
package msci_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    // register selects
    localparam logic [2:0] SEL_IER = 3'h1;
    localparam logic [2:0] SEL_CONTROL = 3'h4;
    localparam logic [2:0] SEL_MSR = 3'h6;
    // modem control bits
    localparam int CTRL_TERM = 0;
    localparam int CTRL_RTS = 1;
    localparam int CTRL_IRQ_OE = 3;
    localparam int CTRL_LOOP = 4;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    // interrupt enable bits
    localparam int IER_RX = 0;
    localparam int IER_TX = 1;
    localparam int IER_LINE = 2;
    localparam int IER_MODEM = 3;
    localparam logic [3:0] IER_RESET = 4'h0;
    // modem status bits
    localparam int MSR_CTS_CHG = 0;
    localparam int MSR_DSR_CHG = 1;
    localparam int MSR_TERI = 2;
    localparam int MSR_DCD = 3;
    localparam logic [3:0] FLAGS_RESET = 4'h0;
    localparam logic [7:0] BUS_IDLE = 8'h00;
    typedef enum logic [1:0] {
        MSCI_IDLE,
        MSCI_READ,
        MSCI_WRITE
    } msci_acc_t;
endpackage

// ===== msci_top.sv
// modem handshake, modem status and channel interrupt logic
`timescale 1ns/100ps
module msci_top
    import msci_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic channel0_select_n,
    input wire logic read_strobe_n,
    input wire logic write_strobe_n,
    input wire logic [msci_pkg::ADDR_W-1:0] reg_select,
    input wire logic [msci_pkg::DATA_W-1:0] data_in,
    output logic [msci_pkg::DATA_W-1:0] data_out,
    output logic data_oe,
    input wire logic clear_send_n,
    input wire logic ready_in_n,
    input wire logic ring_n,
    input wire logic carrier_n,
    input wire logic rx_error,
    input wire logic rx_ready,
    input wire logic tx_empty,
    output logic terminal_ready_n,
    output logic request_send_n,
    output logic channel_irq,
    output logic channel_irq_oe
);
    import msci_pkg::*;

    // ************************************************
    // host access decode
    // ************************************************
    logic rd_now;
    logic wr_now;
    logic rd_reg;
    logic wr_reg;
    msci_acc_t acc_reg;
    logic status_read;
    logic ier_read;
    logic [msci_pkg::ADDR_W-1:0] rd_sel_reg;
    logic [4:0] modem_control_reg;
    logic [3:0] ier_reg;
    logic [3:0] flags_reg;
    logic [3:0] level_reg;
    logic tx_pend_reg;
    logic tx_prev_reg;
    logic [7:0] status_now;

    assign rd_now = !channel0_select_n && !read_strobe_n;
    assign wr_now = !channel0_select_n && !write_strobe_n;

    // strobe edge tracking: act once per strobe
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_reg <= 1'b0;
            wr_reg <= 1'b0;
            acc_reg <= MSCI_IDLE;
        end else begin
            rd_reg <= rd_now;
            wr_reg <= wr_now;
            case ({rd_now, wr_now})
                2'b10: acc_reg <= MSCI_READ;
                2'b01: acc_reg <= MSCI_WRITE;
                default: acc_reg <= MSCI_IDLE;
            endcase
        end
    end

    // the host may move the register select together with the strobe release,
    // so the read target is held from the last cycle the strobe was seen
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_sel_reg <= '0;
        end else if (rd_now) begin
            rd_sel_reg <= reg_select;
        end
    end

    // status flags clear at the end of a status read
    assign status_read = rd_reg && !rd_now && (rd_sel_reg == SEL_MSR);
    assign ier_read = rd_reg && !rd_now && (rd_sel_reg == SEL_IER);

    // ************************************************
    // control registers
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            modem_control_reg <= CTRL_RESET;
            ier_reg <= IER_RESET;
        end else if (wr_now && !wr_reg) begin
            if (reg_select == SEL_CONTROL) begin
                modem_control_reg <= data_in[4:0];
            end
            if (reg_select == SEL_IER) begin
                ier_reg <= data_in[3:0];
            end
        end
    end

    // ************************************************
    // modem status inputs and change flags
    // ************************************************
    // level_reg holds last sampled active-low inputs: cts, dsr, ri, dcd
    // it keeps sampling through reset so a pin already active gives no false change
    always_ff @(posedge clk) begin
        level_reg <= {carrier_n, ring_n, ready_in_n, clear_send_n};
    end

    // set wins over clear so a change on the clearing edge is kept
    always_ff @(posedge clk) begin
        if (reset) begin
            flags_reg <= FLAGS_RESET;
        end else begin
            flags_reg[MSR_CTS_CHG] <= (flags_reg[MSR_CTS_CHG] && !status_read)
                || (clear_send_n != level_reg[0]);
            flags_reg[MSR_DSR_CHG] <= (flags_reg[MSR_DSR_CHG] && !status_read)
                || (ready_in_n != level_reg[1]);
            flags_reg[MSR_TERI] <= (flags_reg[MSR_TERI] && !status_read)
                || (ring_n && !level_reg[2]);
            flags_reg[MSR_DCD] <= (flags_reg[MSR_DCD] && !status_read)
                || (carrier_n != level_reg[3]);
        end
    end

    // status byte: complement levels above change flags
    assign status_now = {~level_reg[3], ~level_reg[2], ~level_reg[1], ~level_reg[0],
        flags_reg};

    // ************************************************
    // read data path
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            data_out <= BUS_IDLE;
            data_oe <= 1'b0;
        end else begin
            data_oe <= rd_now;
            case (reg_select)
                SEL_MSR: data_out <= status_now;
                SEL_CONTROL: data_out <= {3'h0, modem_control_reg};
                SEL_IER: data_out <= {4'h0, ier_reg};
                default: data_out <= BUS_IDLE;
            endcase
        end
    end

    // ************************************************
    // transmit-empty interrupt: cleared by reading the enable register
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            tx_pend_reg <= 1'b0;
            tx_prev_reg <= 1'b0;
        end else begin
            tx_prev_reg <= tx_empty;
            tx_pend_reg <= (tx_pend_reg && !ier_read && tx_empty)
                || (tx_empty && !tx_prev_reg);
        end
    end

    // ************************************************
    // modem outputs and interrupt pin
    // ************************************************
    always_ff @(posedge clk) begin
        if (reset) begin
            terminal_ready_n <= 1'b1;
            request_send_n <= 1'b1;
            channel_irq <= 1'b0;
            channel_irq_oe <= 1'b0;
        end else begin
            terminal_ready_n <= !(modem_control_reg[CTRL_TERM]
                && !modem_control_reg[CTRL_LOOP]);
            request_send_n <= !(modem_control_reg[CTRL_RTS]
                && !modem_control_reg[CTRL_LOOP]);
            channel_irq_oe <= modem_control_reg[CTRL_IRQ_OE];
            channel_irq <= (ier_reg[IER_LINE] && rx_error)
                || (ier_reg[IER_RX] && rx_ready)
                || (ier_reg[IER_TX] && tx_pend_reg)
                || (ier_reg[IER_MODEM] && (|flags_reg));
        end
    end

    // ************************************************
    // checks
    // ************************************************
    property p_dsr_level;
        @(posedge clk) disable iff (reset)
        (rd_now && reg_select == SEL_MSR) |=> (data_out[5] == !$past(level_reg[1]));
    endproperty
    a_dsr_level: assert property (p_dsr_level) else $error("dsr level wrong");

    property p_dsr_flag;
        @(posedge clk) disable iff (reset)
        (ready_in_n != level_reg[1]) |=> flags_reg[MSR_DSR_CHG];
    endproperty
    a_dsr_flag: assert property (p_dsr_flag) else $error("dsr flag missed");

    property p_ring_flag;
        @(posedge clk) disable iff (reset)
        (ring_n && !level_reg[2]) |=> flags_reg[MSR_TERI];
    endproperty
    a_ring_flag: assert property (p_ring_flag) else $error("ring flag missed");

    property p_dcd_flag;
        @(posedge clk) disable iff (reset)
        (carrier_n != level_reg[3]) |=> flags_reg[MSR_DCD];
    endproperty
    a_dcd_flag: assert property (p_dcd_flag) else $error("carrier flag missed");

    sequence s_modem_event;
        ier_reg[IER_MODEM] && (clear_send_n != level_reg[0] || ready_in_n != level_reg[1]);
    endsequence
    property p_modem_irq;
        @(posedge clk) disable iff (reset)
        s_modem_event ##1 ier_reg[IER_MODEM] |=> channel_irq;
    endproperty
    a_modem_irq: assert property (p_modem_irq) else $error("modem irq missing");

    property p_term;
        @(posedge clk) disable iff (reset)
        (modem_control_reg[CTRL_TERM] && !modem_control_reg[CTRL_LOOP]) |=> !terminal_ready_n;
    endproperty
    a_term: assert property (p_term) else $error("terminal ready not low");

    property p_term_off;
        @(posedge clk) disable iff (reset)
        (!modem_control_reg[CTRL_TERM] || modem_control_reg[CTRL_LOOP]) |=> terminal_ready_n;
    endproperty
    a_term_off: assert property (p_term_off) else $error("terminal ready not high");

    property p_rts;
        @(posedge clk) disable iff (reset)
        (modem_control_reg[CTRL_RTS] && !modem_control_reg[CTRL_LOOP]) |=> !request_send_n;
    endproperty
    a_rts: assert property (p_rts) else $error("request to send wrong");

    property p_irq_oe;
        @(posedge clk) disable iff (reset)
        $changed(modem_control_reg[CTRL_IRQ_OE])
            |=> (channel_irq_oe == $past(modem_control_reg[CTRL_IRQ_OE]));
    endproperty
    a_irq_oe: assert property (p_irq_oe) else $error("irq enable wrong");

    property p_flag_keep;
        @(posedge clk) disable iff (reset)
        (status_read && ready_in_n != level_reg[1]) |=> flags_reg[MSR_DSR_CHG];
    endproperty
    a_flag_keep: assert property (p_flag_keep) else $error("change lost");

    property p_rts_off;
        @(posedge clk) disable iff (reset)
        (!modem_control_reg[CTRL_RTS] || modem_control_reg[CTRL_LOOP]) |=> request_send_n;
    endproperty
    a_rts_off: assert property (p_rts_off) else $error("request to send not high");

    property p_cts_flag;
        @(posedge clk) disable iff (reset)
        (clear_send_n != level_reg[0]) |=> flags_reg[MSR_CTS_CHG];
    endproperty
    a_cts_flag: assert property (p_cts_flag) else $error("clear to send flag missed");

    property p_cts_level;
        @(posedge clk) disable iff (reset)
        (rd_now && reg_select == SEL_MSR) |=> (data_out[4] == !$past(level_reg[0]));
    endproperty
    a_cts_level: assert property (p_cts_level) else $error("cts level wrong");

    property p_ring_level;
        @(posedge clk) disable iff (reset)
        (rd_now && reg_select == SEL_MSR) |=> (data_out[6] == !$past(level_reg[2]));
    endproperty
    a_ring_level: assert property (p_ring_level) else $error("ring level wrong");

    property p_dcd_level;
        @(posedge clk) disable iff (reset)
        (rd_now && reg_select == SEL_MSR) |=> (data_out[7] == !$past(level_reg[3]));
    endproperty
    a_dcd_level: assert property (p_dcd_level) else $error("carrier level wrong");

    property p_flag_clear;
        @(posedge clk) disable iff (reset)
        (status_read && ready_in_n == level_reg[1]) |=> !flags_reg[MSR_DSR_CHG];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("dsr flag not cleared");

    property p_write_lands;
        @(posedge clk) disable iff (reset)
        (wr_now && !wr_reg && reg_select == SEL_CONTROL)
            |=> (modem_control_reg == $past(data_in[4:0]));
    endproperty
    a_write_lands: assert property (p_write_lands) else $error("control write lost");

    property p_read_drive;
        @(posedge clk) disable iff (reset)
        (acc_reg == MSCI_READ) |-> data_oe;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("bus not driven on read");

    property p_read_release;
        @(posedge clk) disable iff (reset)
        !rd_now |=> !data_oe;
    endproperty
    a_read_release: assert property (p_read_release) else $error("bus still driven");

    sequence s_ring_event;
        ier_reg[IER_MODEM] && ring_n && !level_reg[2];
    endsequence
    property p_ring_irq;
        @(posedge clk) disable iff (reset)
        s_ring_event ##1 ier_reg[IER_MODEM] |=> channel_irq;
    endproperty
    a_ring_irq: assert property (p_ring_irq) else $error("ring irq missing");

    sequence s_carrier_event;
        ier_reg[IER_MODEM] && (carrier_n != level_reg[3]);
    endsequence
    property p_carrier_irq;
        @(posedge clk) disable iff (reset)
        s_carrier_event ##1 ier_reg[IER_MODEM] |=> channel_irq;
    endproperty
    a_carrier_irq: assert property (p_carrier_irq) else $error("carrier irq missing");

    property p_irq_quiet;
        @(posedge clk) disable iff (reset)
        (ier_reg == IER_RESET) |=> !channel_irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq with no source enabled");
endmodule

// ===== msci_host.sv
// host cpu model driving the channel strobes
`timescale 1ns/100ps
module msci_host
    import msci_pkg::*;
(
    input wire logic clk,
    input wire logic data_oe,
    input wire logic [msci_pkg::DATA_W-1:0] data_out,
    output logic channel0_select_n,
    output logic read_strobe_n,
    output logic write_strobe_n,
    output logic [msci_pkg::ADDR_W-1:0] reg_select,
    output logic [msci_pkg::DATA_W-1:0] data_in
);
    // idle bus, nothing selected
    initial begin
        channel0_select_n = 1'b1;
        read_strobe_n = 1'b1;
        write_strobe_n = 1'b1;
        reg_select = 3'h0;
        data_in = 8'h00;
    end
    // one write, all qualifiers held over the taking edge
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk) #1;
        channel0_select_n = 1'b0;
        reg_select = a;
        data_in = d;
        write_strobe_n = 1'b0;
        @(posedge clk) #1;
        write_strobe_n = 1'b1;
        channel0_select_n = 1'b1;
        reg_select = ~a; // released lines never show the last value
        data_in = ~d;
    endtask
    // one read, held until the device signals it drives the bus
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        int n;
        @(posedge clk) #1;
        channel0_select_n = 1'b0;
        reg_select = a;
        read_strobe_n = 1'b0;
        n = 0;
        do begin
            @(posedge clk) #1;
            n++;
        end while (data_oe !== 1'b1 && n < 8);
        if (n >= 8) begin
            test_modem_status_control_interrupt.give_up();
        end
        d = data_out;
        read_strobe_n = 1'b1;
        channel0_select_n = 1'b1;
        reg_select = ~a;
    endtask
endmodule

// ===== test_modem_status_control_interrupt.sv
// self-checking bench for the modem status and interrupt block
`timescale 1ns/100ps
module test_modem_status_control_interrupt;
    import msci_pkg::*;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic cs_n, rd_n, wr_n, data_oe, trdy_n, rts_n, irq, irq_oe;
    logic [2:0] sel;
    logic [2:0] src = 3'h0; // rx error, tx empty, rx ready as enable bits
    logic [3:0] pins = 4'hf; // carrier, ring, ready, clear-send
    logic [3:0] flags;
    logic [7:0] din, dout, got, m;
    int mismatches = 0;
    int checked = 0;
    int i;
    always #20 clk = ~clk;
    msci_host host(.clk(clk), .data_oe(data_oe), .data_out(dout), .channel0_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reg_select(sel), .data_in(din));
    msci_top u_msci_top(.clk(clk), .reset(reset), .channel0_select_n(cs_n),
        .read_strobe_n(rd_n), .write_strobe_n(wr_n), .reg_select(sel), .data_in(din),
        .data_out(dout), .data_oe(data_oe), .clear_send_n(pins[0]), .ready_in_n(pins[1]),
        .ring_n(pins[2]), .carrier_n(pins[3]), .rx_error(src[2]), .rx_ready(src[0]),
        .tx_empty(src[1]), .terminal_ready_n(trdy_n), .request_send_n(rts_n),
        .channel_irq(irq), .channel_irq_oe(irq_oe));
    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic complete_run();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic give_up();
        mismatches++;
        $display("wrong value at %0t: no bus answer", $time);
        complete_run();
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // status byte: active levels above, change flags below
    function automatic logic [7:0] exp_status(input logic [3:0] p, input logic [3:0] f);
        return {~p, f};
    endfunction
    // main sequence
    initial begin
        m = 8'($urandom(4));
        repeat (8) @(posedge clk);
        #1 reset = 1'b0;
        chk({trdy_n, rts_n, irq, irq_oe, data_oe}, 8'h18);
        for (i = 0; i < 10; i++) begin
            m = (i == 0) ? 8'h13 : ((i == 9) ? 8'h0b : 8'($urandom));
            host.wr(SEL_CONTROL, m);
            wait_clk(2);
            chk({~(m[0] & ~m[4])}, {trdy_n});
            chk({~(m[1] & ~m[4])}, {rts_n});
            chk({m[3]}, {irq_oe});
        end
        host.wr(SEL_IER, 8'h08);
        host.rd(3'h7, got);
        chk(got, 8'h00);
        host.rd(SEL_MSR, got);
        chk(got, exp_status(pins, 4'h0));
        for (i = 0; i < 16; i++) begin
            m = 8'($urandom % 4);
            pins[m[1:0]] = ~pins[m[1:0]];
            flags = 4'h0;
            flags[m[1:0]] = (m[1:0] != 2'd2) || pins[2];
            wait_clk(3);
            chk({|flags}, {irq});
            host.rd(SEL_MSR, got);
            chk(got, exp_status(pins, flags));
            host.rd(SEL_MSR, got);
            chk(got, exp_status(pins, 4'h0));
            wait_clk(2);
            chk({irq}, 8'h00);
        end
        // a change landing on the clearing edge must survive
        fork
            host.rd(SEL_MSR, got);
            begin
                wait_clk(2);
                pins[1] = ~pins[1];
            end
        join
        wait_clk(3);
        host.rd(SEL_MSR, got);
        chk(got, exp_status(pins, 4'h2));
        for (i = 0; i < 3; i++) begin
            host.wr(SEL_IER, 8'h00);
            src = 3'(1 << i);
            wait_clk(3);
            chk({irq}, 8'h00);
            src = 3'h0;
            host.wr(SEL_IER, 8'(1 << i));
            src = 3'(1 << i);
            wait_clk(3);
            chk({irq}, 8'h01);
            src = 3'h0;
            wait_clk(3);
            chk({irq}, 8'h00);
        end
        reset = 1'b1;
        wait_clk(2);
        chk({trdy_n, rts_n, irq, irq_oe}, 8'h0c);
        // released again: no change flag may come out of the reset itself
        reset = 1'b0;
        host.rd(SEL_MSR, got);
        chk(got, exp_status(pins, 4'h0));
        complete_run();
    end
endmodule
